//--- include/ueb_params.svh
`ifndef UEB_PARAMS_SVH
`define UEB_PARAMS_SVH

// register byte addresses on the 8-bit bus
`define UEB_ADR_W 16
`define UEB_ADR_DATA_END 16'hff75
`define UEB_ADR_CLEAR0 16'hff79
`define UEB_ADR_CLEAR1 16'hff7a
`define UEB_ADR_STATUS 16'hff7b

// clear register 0 bit positions
`define UEB_C0_BI_SIE 5
`define UEB_C0_BI_CPU 4
`define UEB_C0_CW 1
`define UEB_C0_CR 0

// clear register 1 bit positions
`define UEB_C1_BO_FULL 1
`define UEB_C1_BO_CPU 0

// data end register bit positions and read/write field
`define UEB_DE_BI 1
`define UEB_DE_CTRL 0
`define UEB_DE_RW_HI 7
`define UEB_DE_RW_LO 6

// status register bit positions
`define UEB_ST_CW_NAK 0
`define UEB_ST_CR_NAK 1
`define UEB_ST_BI_NAK 2
`define UEB_ST_BO_NAK 3
`define UEB_ST_BI_PEND 4

// reset values
`define UEB_RST_BYTE 8'h00
`define UEB_RST_RW 2'h0

// counter layout
`define UEB_CNT_W 7
`define UEB_NCNT 6
`define UEB_CNT_ZERO 7'h00
`define UEB_I_CW 0
`define UEB_I_CR 1
`define UEB_I_BI_CPU 2
`define UEB_I_BI_SIE 3
`define UEB_I_BO_CPU 4
`define UEB_I_BO_SIE 5

`endif

//--- include/ueb_pkg.sv
`include "ueb_params.svh"

package ueb_pkg;

  // packet length class handed to the serial engine
  typedef enum logic [1:0] {
    UEB_KIND_FULL = 2'b00,
    UEB_KIND_SHORT = 2'b01,
    UEB_KIND_NULL = 2'b10
  } ueb_kind_t;

  // bulk-in hand-over sequencer
  typedef enum logic {
    UEB_BI_IDLE = 1'b0,
    UEB_BI_WAIT = 1'b1
  } ueb_bi_state_t;

  typedef struct packed {
    logic [`UEB_CNT_W-1:0] cnt;
  } ueb_cnt_state_t;

  typedef struct packed {
    logic ack;
    logic [7:0] rdat;
    logic [1:0] dend_rw;
    logic cw_nak;
    logic cr_nak;
    logic cr_nak_hw;
    logic bi_nak;
    logic bo_nak;
    logic bo_nak_hw;
    ueb_bi_state_t bi_st;
    logic bi_start;
    ueb_kind_t bi_kind;
    logic [`UEB_CNT_W-1:0] bi_len;
    logic c_start;
    ueb_kind_t c_kind;
    logic [`UEB_CNT_W-1:0] c_len;
  } ueb_state_t;

endpackage

//--- rtl/ueb_counter.sv
`timescale 1ns/1ps
`include "ueb_params.svh"

module ueb_counter
  import ueb_pkg::*;
#(
  parameter int DEPTH = 64
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // count control
  input wire logic clr_i,
  input wire logic load_i,
  input wire logic [`UEB_CNT_W-1:0] load_val_i,
  input wire logic inc_i,
  input wire logic dec_i,
  // state
  output logic [`UEB_CNT_W-1:0] cnt_o,
  output logic full_o
);

  localparam logic [`UEB_CNT_W-1:0] FULL_CNT = `UEB_CNT_W'(DEPTH);

  ueb_cnt_state_t st_reg;
  ueb_cnt_state_t st_next;

  // clear beats load, load beats byte traffic
  always_comb
  begin
    st_next = st_reg;
    if (clr_i)
    begin
      st_next.cnt = `UEB_CNT_ZERO;
    end
    else if (load_i)
    begin
      st_next.cnt = load_val_i;
    end
    else if (inc_i && !dec_i && st_reg.cnt != FULL_CNT)
    begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
    else if (dec_i && !inc_i && st_reg.cnt != `UEB_CNT_ZERO)
    begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign cnt_o = st_reg.cnt;
  assign full_o = (st_reg.cnt == FULL_CNT);

endmodule

//--- rtl/ueb_top.sv
`timescale 1ns/1ps
`include "ueb_params.svh"
// Operation
// - clear register 0 takes byte writes only and always reads back zero
// - writing one to a clear bit clears that buffer once; zero does nothing
// - clear and data-end bits of a disabled endpoint are ignored
// - bulk-in sie-side clear empties only that half and its counter
// - sie-side clear ignored during endpoint 1 in token with bulk-in nak set
// - any bulk-in sie-side clear drops the bulk-in nak flag
// - ep0 write clear ignored during endpoint 0 in token with write nak set
// - ep0 write clear zeroes its counter and drops the write nak flag
// - ep0 read clear zeroes the read buffer counter
// - ep0 read clear drops the read nak only when hardware set it
// - bulk-out full clear empties both halves and their counters
// - bulk-out cpu clear empties only the cpu half
// - either bulk-out clear drops bulk-out nak only when hardware set it
// - data-end register reads zero except read/write bits 7 and 6
// - writing one to a data-end bit starts sending once; zero does nothing
// - bulk-in data end swaps halves when possible, sets nak, sends
// - bulk-in data end with empty cpu half sends a zero-length packet
// - bulk-in data end with partial buffer sends a short packet
// - a full bulk-in cpu half starts sending without data end
// - ep0 data end sets the write nak flag and sends the write buffer
// - with status bit 1, ep0 data end sends null or short packets unless the write buffer is full

module ueb_top
  import ueb_pkg::*;
#(
  parameter int CTRL_DEPTH = 8,
  parameter int BULK_DEPTH = 64
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave, 8-bit data
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`UEB_ADR_W-1:0] adr_i,
  input wire logic sel_i,
  input wire logic [7:0] dat_i,
  output logic [7:0] dat_o,
  output logic ack_o,
  // endpoint enables from mask and interface setting, and ep0 status bit 1
  input wire logic bulk_in_en_i,
  input wire logic bulk_out_en_i,
  input wire logic ep0_status_bit1_i,
  // serial engine token state
  input wire logic in_token_ep0_i,
  input wire logic in_token_ep1_i,
  // buffer byte traffic
  input wire logic ctrl_write_byte_i,
  input wire logic ctrl_read_sie_byte_i,
  input wire logic ctrl_read_cpu_byte_i,
  input wire logic bulk_in_cpu_byte_i,
  input wire logic bulk_out_sie_byte_i,
  input wire logic bulk_out_cpu_byte_i,
  // serial engine completions
  input wire logic ctrl_tx_done_i,
  input wire logic bulk_in_tx_done_i,
  input wire logic bulk_out_rx_end_i,
  // nak flag sources outside this block
  input wire logic ctrl_read_nak_hw_set_i,
  input wire logic ctrl_read_nak_fw_set_i,
  input wire logic ctrl_read_nak_release_i,
  input wire logic bulk_out_nak_fw_set_i,
  input wire logic bulk_out_nak_release_i,
  // transmit requests to the serial engine
  output logic ctrl_tx_start_o,
  output ueb_kind_t ctrl_tx_kind_o,
  output logic [`UEB_CNT_W-1:0] ctrl_tx_len_o,
  output logic bulk_in_tx_start_o,
  output ueb_kind_t bulk_in_tx_kind_o,
  output logic [`UEB_CNT_W-1:0] bulk_in_tx_len_o,
  // flags and buffer state
  output logic ctrl_write_nak_flag_o,
  output logic ctrl_read_nak_flag_o,
  output logic bulk_in_nak_flag_o,
  output logic bulk_out_nak_flag_o,
  output logic [`UEB_CNT_W-1:0] bulk_out_cpu_cnt_o,
  output logic [`UEB_NCNT-1:0] fifo_clear_o
);

  ueb_state_t st_reg;
  ueb_state_t st_next;

  logic req;
  logic wr_fire;
  logic fire0;
  logic fire1;
  logic fired;
  logic bulk_in_sie_side_clear;
  logic bulk_in_cpu_side_clear;
  logic ctrl_write_buffer_clear;
  logic ctrl_read_buffer_clear;
  logic bulk_out_full_clear;
  logic bulk_out_cpu_side_clear;
  logic bulk_in_data_end;
  logic ctrl_data_end;
  logic bi_swap;
  logic bo_swap;
  logic [`UEB_NCNT-1:0] c_clr;
  logic [`UEB_NCNT-1:0] c_load;
  logic [`UEB_NCNT-1:0] c_inc;
  logic [`UEB_NCNT-1:0] c_dec;
  logic [`UEB_NCNT-1:0] c_full;
  logic [`UEB_CNT_W-1:0] c_ldv [`UEB_NCNT];
  logic [`UEB_CNT_W-1:0] c_cnt [`UEB_NCNT];

  // a write takes effect only at the edge where ack is high
  assign req = cyc_i && stb_i;
  assign wr_fire = req && we_i && sel_i && st_reg.ack;
  assign fire0 = wr_fire && (adr_i == `UEB_ADR_CLEAR0);
  assign fire1 = wr_fire && (adr_i == `UEB_ADR_CLEAR1);
  assign fired = wr_fire && (adr_i == `UEB_ADR_DATA_END);

  // self-clearing bits never store; each is a pulse of the write cycle
  assign bulk_in_sie_side_clear = fire0 && dat_i[`UEB_C0_BI_SIE] && bulk_in_en_i
    && !(in_token_ep1_i && st_reg.bi_nak);
  assign bulk_in_cpu_side_clear = fire0 && dat_i[`UEB_C0_BI_CPU] && bulk_in_en_i;
  assign ctrl_write_buffer_clear = fire0 && dat_i[`UEB_C0_CW]
    && !(in_token_ep0_i && st_reg.cw_nak);
  assign ctrl_read_buffer_clear = fire0 && dat_i[`UEB_C0_CR];
  assign bulk_out_full_clear = fire1 && dat_i[`UEB_C1_BO_FULL] && bulk_out_en_i;
  assign bulk_out_cpu_side_clear = fire1 && dat_i[`UEB_C1_BO_CPU] && bulk_out_en_i;
  assign bulk_in_data_end = fired && dat_i[`UEB_DE_BI] && bulk_in_en_i;
  assign ctrl_data_end = fired && dat_i[`UEB_DE_CTRL];

  // bulk-in halves swap only once the sie half is empty and the bulk-in nak flag is down
  assign bi_swap = (st_reg.bi_st == UEB_BI_WAIT) && !st_reg.bi_nak
    && (c_cnt[`UEB_I_BI_SIE] == `UEB_CNT_ZERO) && !bulk_in_sie_side_clear;
  // a received bulk-out packet moves to the cpu half when that half is empty and no bulk-out clear fires
  assign bo_swap = bulk_out_rx_end_i && (c_cnt[`UEB_I_BO_CPU] == `UEB_CNT_ZERO)
    && !bulk_out_full_clear && !bulk_out_cpu_side_clear;

  // counter control, clear strobes win over traffic inside the counter
  always_comb
  begin
    c_clr = '0;
    c_load = '0;
    c_inc = '0;
    c_dec = '0;
    for (int i = 0; i < `UEB_NCNT; i++)
    begin
      c_ldv[i] = `UEB_CNT_ZERO;
    end
    c_clr[`UEB_I_CW] = ctrl_write_buffer_clear || ctrl_tx_done_i;
    c_inc[`UEB_I_CW] = ctrl_write_byte_i;
    c_clr[`UEB_I_CR] = ctrl_read_buffer_clear;
    c_inc[`UEB_I_CR] = ctrl_read_sie_byte_i;
    c_dec[`UEB_I_CR] = ctrl_read_cpu_byte_i;
    c_clr[`UEB_I_BI_CPU] = bulk_in_cpu_side_clear || bi_swap;
    c_inc[`UEB_I_BI_CPU] = bulk_in_cpu_byte_i;
    c_clr[`UEB_I_BI_SIE] = bulk_in_sie_side_clear || bulk_in_tx_done_i;
    c_load[`UEB_I_BI_SIE] = bi_swap;
    c_ldv[`UEB_I_BI_SIE] = c_cnt[`UEB_I_BI_CPU];
    c_clr[`UEB_I_BO_CPU] = bulk_out_full_clear || bulk_out_cpu_side_clear;
    c_load[`UEB_I_BO_CPU] = bo_swap;
    c_ldv[`UEB_I_BO_CPU] = c_cnt[`UEB_I_BO_SIE];
    c_dec[`UEB_I_BO_CPU] = bulk_out_cpu_byte_i;
    c_clr[`UEB_I_BO_SIE] = bulk_out_full_clear || bo_swap;
    c_inc[`UEB_I_BO_SIE] = bulk_out_sie_byte_i;
  end

  // one byte counter per buffer half; ep0 buffers are shallower
  for (genvar g = 0; g < `UEB_NCNT; g++)
  begin : g_cnt
    ueb_counter #(
      .DEPTH((g <= `UEB_I_CR) ? CTRL_DEPTH : BULK_DEPTH)
    ) u_cnt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clr_i(c_clr[g]),
      .load_i(c_load[g]),
      .load_val_i(c_ldv[g]),
      .inc_i(c_inc[g]),
      .dec_i(c_dec[g]),
      .cnt_o(c_cnt[g]),
      .full_o(c_full[g])
    );
  end

  // bus answer, flags and transmit sequencing
  always_comb
  begin
    st_next = st_reg;
    st_next.bi_start = 1'b0;
    st_next.c_start = 1'b0;
    // ack one cycle after the request, dropped the cycle after
    st_next.ack = req && !st_reg.ack;
    if (req && !st_reg.ack)
    begin
      st_next.rdat = `UEB_RST_BYTE;
      if (adr_i == `UEB_ADR_DATA_END)
      begin
        st_next.rdat[`UEB_DE_RW_HI:`UEB_DE_RW_LO] = st_reg.dend_rw;
      end
      else if (adr_i == `UEB_ADR_STATUS)
      begin
        st_next.rdat[`UEB_ST_CW_NAK] = st_reg.cw_nak;
        st_next.rdat[`UEB_ST_CR_NAK] = st_reg.cr_nak;
        st_next.rdat[`UEB_ST_BI_NAK] = st_reg.bi_nak;
        st_next.rdat[`UEB_ST_BO_NAK] = st_reg.bo_nak;
        st_next.rdat[`UEB_ST_BI_PEND] = (st_reg.bi_st == UEB_BI_WAIT);
      end
    end
    if (fired)
    begin
      st_next.dend_rw = dat_i[`UEB_DE_RW_HI:`UEB_DE_RW_LO];
    end

    // ep0 write: data end sets nak and hands the buffer over
    if (ctrl_write_buffer_clear || ctrl_tx_done_i)
    begin
      st_next.cw_nak = 1'b0;
    end
    if (ctrl_data_end)
    begin
      st_next.cw_nak = 1'b1;
      st_next.c_start = 1'b1;
      st_next.c_len = c_cnt[`UEB_I_CW];
      st_next.c_kind = UEB_KIND_FULL;
      if (ep0_status_bit1_i && c_cnt[`UEB_I_CW] == `UEB_CNT_ZERO)
      begin
        st_next.c_kind = UEB_KIND_NULL;
      end
      else if (ep0_status_bit1_i && !c_full[`UEB_I_CW])
      begin
        st_next.c_kind = UEB_KIND_SHORT;
      end
    end

    // ep0 read nak: clear only drops a hardware-set flag; a new set wins
    if (ctrl_read_nak_release_i || (ctrl_read_buffer_clear && st_reg.cr_nak_hw))
    begin
      st_next.cr_nak = 1'b0;
      st_next.cr_nak_hw = 1'b0;
    end
    if (ctrl_read_nak_fw_set_i)
    begin
      st_next.cr_nak = 1'b1;
      st_next.cr_nak_hw = 1'b0;
    end
    else if (ctrl_read_nak_hw_set_i)
    begin
      st_next.cr_nak = 1'b1;
      st_next.cr_nak_hw = 1'b1;
    end

    // bulk-out nak: raised by hardware when a packet finds the cpu half busy
    if (bulk_out_nak_release_i
        || ((bulk_out_full_clear || bulk_out_cpu_side_clear) && st_reg.bo_nak_hw))
    begin
      st_next.bo_nak = 1'b0;
      st_next.bo_nak_hw = 1'b0;
    end
    if (bulk_out_nak_fw_set_i)
    begin
      st_next.bo_nak = 1'b1;
      st_next.bo_nak_hw = 1'b0;
    end
    else if (bulk_out_rx_end_i && !bo_swap)
    begin
      st_next.bo_nak = 1'b1;
      st_next.bo_nak_hw = 1'b1;
    end

    // bulk-in: data end or a full cpu half queues a hand-over
    if (bulk_in_sie_side_clear || bulk_in_tx_done_i)
    begin
      st_next.bi_nak = 1'b0;
    end
    case (st_reg.bi_st)
      UEB_BI_IDLE:
      begin
        if (bulk_in_data_end || c_full[`UEB_I_BI_CPU])
        begin
          st_next.bi_st = UEB_BI_WAIT;
        end
      end
      UEB_BI_WAIT:
      begin
        if (bi_swap)
        begin
          st_next.bi_st = UEB_BI_IDLE;
          st_next.bi_nak = 1'b1;
          st_next.bi_start = 1'b1;
          st_next.bi_len = c_cnt[`UEB_I_BI_CPU];
          if (c_cnt[`UEB_I_BI_CPU] == `UEB_CNT_ZERO)
          begin
            st_next.bi_kind = UEB_KIND_NULL;
          end
          else if (!c_full[`UEB_I_BI_CPU])
          begin
            st_next.bi_kind = UEB_KIND_SHORT;
          end
          else
          begin
            st_next.bi_kind = UEB_KIND_FULL;
          end
        end
      end
      default:
      begin
        st_next.bi_st = UEB_BI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign ack_o = st_reg.ack;
  assign dat_o = st_reg.rdat;
  assign ctrl_tx_start_o = st_reg.c_start;
  assign ctrl_tx_kind_o = st_reg.c_kind;
  assign ctrl_tx_len_o = st_reg.c_len;
  assign bulk_in_tx_start_o = st_reg.bi_start;
  assign bulk_in_tx_kind_o = st_reg.bi_kind;
  assign bulk_in_tx_len_o = st_reg.bi_len;
  assign ctrl_write_nak_flag_o = st_reg.cw_nak;
  assign ctrl_read_nak_flag_o = st_reg.cr_nak;
  assign bulk_in_nak_flag_o = st_reg.bi_nak;
  assign bulk_out_nak_flag_o = st_reg.bo_nak;
  assign bulk_out_cpu_cnt_o = c_cnt[`UEB_I_BO_CPU];
  // clear strobes toward the buffer data path, one bit per clear source
  assign fifo_clear_o = {bulk_out_full_clear, bulk_out_cpu_side_clear,
    bulk_in_sie_side_clear, bulk_in_cpu_side_clear,
    ctrl_write_buffer_clear, ctrl_read_buffer_clear};

endmodule

//--- bench/ueb_top_props.sv
`timescale 1ns/1ps
`include "ueb_params.svh"
module ueb_top_props
  import ueb_pkg::*;
#(
  parameter int BULK_DEPTH = 64
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [`UEB_ADR_W-1:0] adr_i,
  input wire logic sel_i,
  input wire logic [7:0] dat_i,
  input wire logic [7:0] dat_o,
  input wire logic ack_o,
  // endpoint state
  input wire logic bulk_in_en_i,
  input wire logic in_token_ep0_i,
  input wire logic in_token_ep1_i,
  input wire logic ctrl_tx_start_o,
  input wire logic bulk_in_tx_start_o,
  input wire ueb_kind_t bulk_in_tx_kind_o,
  input wire logic [`UEB_CNT_W-1:0] bulk_in_tx_len_o,
  input wire logic ctrl_write_nak_flag_o,
  input wire logic bulk_in_nak_flag_o,
  input wire logic [`UEB_CNT_W-1:0] bulk_out_cpu_cnt_o,
  input wire logic [`UEB_NCNT-1:0] fifo_clear_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic wr_ack;
  // a write that takes effect at the coming edge
  assign wr_ack = ack_o && cyc_i && stb_i && we_i && sel_i;
  sequence s_rd_req; cyc_i && stb_i && !we_i && !ack_o; endsequence
  sequence s_ctrl_de; wr_ack && adr_i == `UEB_ADR_DATA_END && dat_i[0]; endsequence
  property p_rd_clear; s_rd_req ##0 (adr_i == `UEB_ADR_CLEAR0 || adr_i == `UEB_ADR_CLEAR1)
    |=> ack_o && dat_o == 8'h00; endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("clear register read not zero");
  property p_rd_dend; s_rd_req ##0 adr_i == `UEB_ADR_DATA_END |=> dat_o[5:0] == 6'h00; endproperty
  a_rd_dend: assert property (p_rd_dend) else $error("data end strobe bits read back");
  property p_strobe; (|fifo_clear_o) |-> wr_ack ##1 fifo_clear_o == 6'h00; endproperty
  a_strobe: assert property (p_strobe) else $error("clear strobe not one write cycle");
  property p_bi_gate; (fifo_clear_o[3] || fifo_clear_o[2]) |-> bulk_in_en_i; endproperty
  a_bi_gate: assert property (p_bi_gate) else $error("bulk-in clear while disabled");
  property p_bi_busy; wr_ack && adr_i == `UEB_ADR_CLEAR0 && dat_i[5] && in_token_ep1_i
    && bulk_in_nak_flag_o |-> !fifo_clear_o[3]; endproperty
  a_bi_busy: assert property (p_bi_busy) else $error("sie clear during in token");
  property p_bi_nak; fifo_clear_o[3] |=> !bulk_in_nak_flag_o || bulk_in_tx_start_o; endproperty
  a_bi_nak: assert property (p_bi_nak) else $error("bulk-in nak kept after clear");
  property p_cw_busy; wr_ack && adr_i == `UEB_ADR_CLEAR0 && dat_i[1] && in_token_ep0_i
    && ctrl_write_nak_flag_o |-> !fifo_clear_o[1]; endproperty
  a_cw_busy: assert property (p_cw_busy) else $error("ctrl write clear during in token");
  property p_cw_nak; fifo_clear_o[1] |=> !ctrl_write_nak_flag_o; endproperty
  a_cw_nak: assert property (p_cw_nak) else $error("ctrl write nak kept after clear");
  property p_ctrl_de; s_ctrl_de |=> ctrl_tx_start_o ##[0:1] ctrl_write_nak_flag_o; endproperty
  a_ctrl_de: assert property (p_ctrl_de) else $error("ctrl data end did not send");
  property p_bo_cnt; (fifo_clear_o[5] || fifo_clear_o[4]) |=> bulk_out_cpu_cnt_o == 7'h00; endproperty
  a_bo_cnt: assert property (p_bo_cnt) else $error("bulk-out count kept after clear");
  property p_bi_kind; bulk_in_tx_start_o |-> bulk_in_tx_kind_o == (bulk_in_tx_len_o == 7'h00 ?
    UEB_KIND_NULL : (bulk_in_tx_len_o == BULK_DEPTH ? UEB_KIND_FULL : UEB_KIND_SHORT)); endproperty
  a_bi_kind: assert property (p_bi_kind) else $error("bulk-in packet class wrong");
endmodule

bind ueb_top ueb_top_props #(.BULK_DEPTH(BULK_DEPTH)) u_props (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .bulk_in_en_i, .in_token_ep0_i, .in_token_ep1_i,
  .ctrl_tx_start_o, .bulk_in_tx_start_o, .bulk_in_tx_kind_o, .bulk_in_tx_len_o,
  .ctrl_write_nak_flag_o, .bulk_in_nak_flag_o, .bulk_out_cpu_cnt_o, .fifo_clear_o);

//--- bench/ueb_sie_model.sv
`timescale 1ns/1ps
module ueb_sie_model #(
  parameter int DLY = 40
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // packet requests from the block
  input wire logic ctrl_tx_start_i,
  input wire logic bulk_in_tx_start_i,
  // packet taken by the host
  output logic ctrl_tx_done_o,
  output logic bulk_in_tx_done_o
);
  int c_cnt;
  int b_cnt;
  // the host is slow on purpose so that nak flags stay up long enough to matter
  always_ff @(posedge clk_i)
  begin
    ctrl_tx_done_o <= !rst_i && c_cnt == 1;
    bulk_in_tx_done_o <= !rst_i && b_cnt == 1;
    c_cnt <= rst_i ? 0 : (ctrl_tx_start_i ? DLY : (c_cnt > 0 ? c_cnt - 1 : 0));
    b_cnt <= rst_i ? 0 : (bulk_in_tx_start_i ? DLY : (b_cnt > 0 ? b_cnt - 1 : 0));
  end
endmodule

//--- bench/usb_endpoint_fifo_clear_and_tx_end_tb.sv
`timescale 1ns/1ps
`include "ueb_params.svh"
module usb_endpoint_fifo_clear_and_tx_end_tb;
  import ueb_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
  logic bi_en = 1'b0, bo_en = 1'b1, st1 = 1'b1, tok0 = 1'b0, tok1 = 1'b0;
  logic [15:0] adr_i = 16'h0000;
  logic [7:0] dat_i = 8'h00, dat_o, q;
  logic [11:0] p = 12'h000;
  logic c_st, b_st, c_dn, b_dn, cw_nak, cr_nak, bi_nak, bo_nak;
  ueb_kind_t c_kind, b_kind, ck, bk;
  logic [6:0] c_len, b_len, cl, bl, bo_cnt;
  logic [5:0] fc_o, fc;
  int error_cnt = 0, checked = 0, cyc_cnt = 0, cn = 0, bn = 0, b0;

  always #12.5 clk_i = ~clk_i;

  ueb_top #(.CTRL_DEPTH(8), .BULK_DEPTH(64)) u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
    .adr_i, .sel_i(cyc_i), .dat_i, .dat_o, .ack_o, .bulk_in_en_i(bi_en), .bulk_out_en_i(bo_en),
    .ep0_status_bit1_i(st1), .in_token_ep0_i(tok0), .in_token_ep1_i(tok1),
    .ctrl_write_byte_i(p[0]), .ctrl_read_sie_byte_i(p[1]), .ctrl_read_cpu_byte_i(p[2]),
    .bulk_in_cpu_byte_i(p[3]), .bulk_out_sie_byte_i(p[4]), .bulk_out_cpu_byte_i(p[5]),
    .ctrl_tx_done_i(c_dn), .bulk_in_tx_done_i(b_dn), .bulk_out_rx_end_i(p[6]),
    .ctrl_read_nak_hw_set_i(p[7]), .ctrl_read_nak_fw_set_i(p[8]), .ctrl_read_nak_release_i(p[9]),
    .bulk_out_nak_fw_set_i(p[10]), .bulk_out_nak_release_i(p[11]), .ctrl_tx_start_o(c_st),
    .ctrl_tx_kind_o(c_kind), .ctrl_tx_len_o(c_len), .bulk_in_tx_start_o(b_st),
    .bulk_in_tx_kind_o(b_kind), .bulk_in_tx_len_o(b_len), .ctrl_write_nak_flag_o(cw_nak),
    .ctrl_read_nak_flag_o(cr_nak), .bulk_in_nak_flag_o(bi_nak), .bulk_out_nak_flag_o(bo_nak),
    .bulk_out_cpu_cnt_o(bo_cnt), .fifo_clear_o(fc_o));
  ueb_sie_model #(.DLY(40)) u_sie (.clk_i, .rst_i, .ctrl_tx_start_i(c_st),
    .bulk_in_tx_start_i(b_st), .ctrl_tx_done_o(c_dn), .bulk_in_tx_done_o(b_dn));

  // count start pulses and keep what each announced; also cut a hang short
  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (c_st === 1'b1)
    begin
      cn <= cn + 1;
      ck <= c_kind;
      cl <= c_len;
    end
    if (b_st === 1'b1)
    begin
      bn <= bn + 1;
      bk <= b_kind;
      bl <= b_len;
    end
    if (cyc_cnt == 5000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // pulse inputs are high for n edges, so n bytes move
  task automatic pulse(input int i, input int n);
    p <= p | 12'(1 << i);
    tick(n);
    p <= p & ~12'(1 << i);
    tick(1);
  endtask

  // one classic cycle, started on an edge; request held until ack is sampled high,
  // read data and clear strobes taken at that edge, then cyc and stb low for a cycle
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1)
    begin
      @(posedge clk_i);
    end
    q = dat_o;
    fc = fc_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_tx(input int c0, input int bb);
    int n = 0;
    while (cn == c0 && bn == bb && n < 40)
    begin
      tick(1);
      n++;
    end
  endtask

  // write, then count the packets it started
  task automatic send(input logic [15:0] a, input logic [7:0] d, input int ec, input int eb);
    int c0 = cn;
    int bb = bn;
    wb(1'b1, a, d);
    if (ec + eb > 0)
      wait_tx(c0, bb);
    else
      tick(10);
    chk("ctrl starts", 8'(cn - c0), 8'(ec));
    chk("bulk starts", 8'(bn - bb), 8'(eb));
  endtask

  initial
  begin
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    wb(1'b0, `UEB_ADR_CLEAR0, 8'h00);
    chk("clear0 read", q, 8'h00);
    wb(1'b0, `UEB_ADR_CLEAR1, 8'h00);
    chk("clear1 read", q, 8'h00);
    wb(1'b1, `UEB_ADR_DATA_END, 8'hc0);
    wb(1'b0, `UEB_ADR_DATA_END, 8'h00);
    chk("data end read", q, 8'hc0);
    wb(1'b1, `UEB_ADR_DATA_END, 8'h00);
    wb(1'b0, 16'hff00, 8'h00);
    chk("unmapped read", q, 8'h00);
    send(`UEB_ADR_CLEAR0, 8'h00, 0, 0);
    chk("zero write strobe", 8'(fc), 8'h00);
    $display("test registers done");
    pulse(0, 3);
    send(`UEB_ADR_DATA_END, 8'h01, 1, 0);
    chk("ctrl kind", 8'(ck), 8'(UEB_KIND_SHORT));
    chk("ctrl len", 8'(cl), 8'h03);
    chk("ctrl write nak", 8'(cw_nak), 8'h01);
    tok0 <= 1'b1;
    send(`UEB_ADR_CLEAR0, 8'h02, 0, 0);
    chk("ctrl clear blocked", 8'(fc), 8'h00);
    chk("ctrl nak held", 8'(cw_nak), 8'h01);
    tok0 <= 1'b0;
    send(`UEB_ADR_CLEAR0, 8'h02, 0, 0);
    chk("ctrl clear", 8'(fc), 8'h02);
    chk("ctrl nak dropped", 8'(cw_nak), 8'h00);
    send(`UEB_ADR_DATA_END, 8'h01, 1, 0);
    chk("ctrl null", 8'(ck), 8'(UEB_KIND_NULL));
    $display("test control done");
    send(`UEB_ADR_DATA_END, 8'h02, 0, 0);
    send(`UEB_ADR_CLEAR0, 8'h30, 0, 0);
    chk("disabled clear", 8'(fc), 8'h00);
    bi_en <= 1'b1;
    pulse(3, 5);
    send(`UEB_ADR_DATA_END, 8'h02, 0, 1);
    chk("bulk kind", 8'(bk), 8'(UEB_KIND_SHORT));
    chk("bulk len", 8'(bl), 8'h05);
    chk("bulk nak", 8'(bi_nak), 8'h01);
    tok1 <= 1'b1;
    send(`UEB_ADR_CLEAR0, 8'h20, 0, 0);
    chk("sie clear blocked", 8'(fc), 8'h00);
    tok1 <= 1'b0;
    // cpu half is empty here, as firmware must ensure before a sie clear
    send(`UEB_ADR_CLEAR0, 8'h20, 0, 0);
    chk("sie clear", 8'(fc), 8'h08);
    chk("bulk nak dropped", 8'(bi_nak), 8'h00);
    tick(50);
    pulse(3, 2);
    send(`UEB_ADR_CLEAR0, 8'h10, 0, 0);
    chk("cpu clear", 8'(fc), 8'h04);
    send(`UEB_ADR_DATA_END, 8'h02, 0, 1);
    chk("bulk null", 8'(bk), 8'(UEB_KIND_NULL));
    tick(50);
    b0 = bn;
    pulse(3, 64);
    wait_tx(cn, b0);
    chk("auto start", 8'(bn - b0), 8'h01);
    chk("full kind", 8'(bk), 8'(UEB_KIND_FULL));
    chk("full len", 8'(bl), 8'h40);
    $display("test bulk in done");
    pulse(4, 4);
    pulse(6, 1);
    send(`UEB_ADR_CLEAR1, 8'h01, 0, 0);
    chk("out cpu clear", 8'(fc), 8'h10);
    chk("out cpu count", 8'(bo_cnt), 8'h00);
    pulse(4, 4);
    pulse(6, 1);
    pulse(4, 2);
    pulse(6, 1);
    chk("out nak by hw", 8'(bo_nak), 8'h01);
    send(`UEB_ADR_CLEAR1, 8'h02, 0, 0);
    chk("out full clear", 8'(fc), 8'h20);
    chk("out count", 8'(bo_cnt), 8'h00);
    chk("out hw nak dropped", 8'(bo_nak), 8'h00);
    pulse(10, 1);
    send(`UEB_ADR_CLEAR1, 8'h01, 0, 0);
    chk("out fw nak kept", 8'(bo_nak), 8'h01);
    pulse(11, 1);
    bo_en <= 1'b0;
    send(`UEB_ADR_CLEAR1, 8'h03, 0, 0);
    chk("out disabled", 8'(fc), 8'h00);
    $display("test bulk out done");
    pulse(7, 1);
    send(`UEB_ADR_CLEAR0, 8'h01, 0, 0);
    chk("read clear", 8'(fc), 8'h01);
    chk("read hw nak dropped", 8'(cr_nak), 8'h00);
    pulse(8, 1);
    send(`UEB_ADR_CLEAR0, 8'h01, 0, 0);
    chk("read fw nak kept", 8'(cr_nak), 8'h01);
    wb(1'b0, `UEB_ADR_STATUS, 8'h00);
    chk("status read", q, 8'h02);
    pulse(9, 1);
    $display("test control read done");
    // status bit 1 low: ep0 data end always announces a full packet
    st1 <= 1'b0;
    pulse(0, 2);
    send(`UEB_ADR_DATA_END, 8'h01, 1, 0);
    chk("ctrl full kind", 8'(ck), 8'(UEB_KIND_FULL));
    chk("ctrl full len", 8'(cl), 8'h02);
    $display("test control plain done");
    conclude();
  end
endmodule
